// >>> dv/core_model.sv
// Core-side model driving exception entry, return and live updates
`timescale 1ns/1ns
`default_nettype none
module core_model (
	input wire logic aclk, // Core clock
	output logic secure_state, // Secure state
	output logic exc_entry, // Entry commit pulse
	output logic [3:0] exc_entry_mode, // Mode entered
	output logic [31:0] exc_entry_status, // New live word
	output logic exc_return, // Return commit pulse
	output logic live_wr, // Live update pulse
	output logic [31:0] live_wr_data // Live update word
);
	// Quiet core at time zero
	initial begin
		secure_state = 1'b0;
		exc_entry = 1'b0;
		exc_entry_mode = 4'h0;
		exc_entry_status = 32'h0;
		exc_return = 1'b0;
		live_wr = 1'b0;
		live_wr_data = 32'h0;
	end
	// Entry commit for one cycle; payload is garbled once released
	task automatic enter(input logic [3:0] m, input logic [31:0] s);
		@(posedge aclk);
		exc_entry <= 1'b1;
		exc_entry_mode <= m;
		exc_entry_status <= s;
		@(posedge aclk);
		exc_entry <= 1'b0;
		exc_entry_mode <= ~m;
		exc_entry_status <= ~s;
	endtask
	// Return commit for one cycle
	task automatic ret();
		@(posedge aclk);
		exc_return <= 1'b1;
		@(posedge aclk);
		exc_return <= 1'b0;
	endtask
	// Core update of the live word
	task automatic wlive(input logic [31:0] d);
		@(posedge aclk);
		live_wr <= 1'b1;
		live_wr_data <= d;
		@(posedge aclk);
		live_wr <= 1'b0;
		live_wr_data <= ~d;
	endtask
	// Security state change
	task automatic sec(input logic s);
		@(posedge aclk);
		secure_state <= s;
	endtask
endmodule
`default_nettype wire

// >>> dv/saved_status_register_bank_test.sv
// Self-checking bench for the saved status register bank
`timescale 1ns/1ns
`default_nettype none
`include "ssr_regs.svh"
module saved_status_register_bank_test import ssr_pkg::*;;
	logic aclk, aresetn, ee_reset_cfg, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, exc_entry_status, live_wr_data, live_status;
	logic [3:0] s_axi_wstrb, exc_entry_mode;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic secure_state, exc_entry, exc_return, live_wr, restore_done;
	int error_cnt, num_checks;
	logic [31:0] wr_tab [4] = '{32'h0000E017, 32'h00000015, 32'h00000016, 32'h00000016};
	logic [31:0] exp_tab [4] = '{32'h00000017, 32'h00000017, 32'h00000017, 32'h00000016};
	logic [3:0] sec_tab = 4'h8;

	saved_status_register_bank dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ee_reset_cfg, .secure_state, .exc_entry, .exc_entry_mode,
		.exc_entry_status, .exc_return, .live_wr, .live_wr_data, .live_status, .restore_done);
	core_model core (.aclk, .secure_state, .exc_entry, .exc_entry_mode, .exc_entry_status, .exc_return,
		.live_wr, .live_wr_data);

	// 50 ns clock
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// Compare tasks
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk_word({30'h0, got}, {30'h0, exp});
	endtask
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				w_ok = 1'b1;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		s_axi_bready <= 1'b0;
		chk_resp(s_axi_bresp, er);
	endtask
	// Read with expected data and response
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		s_axi_rready <= 1'b0;
		chk_resp(s_axi_rresp, er);
		chk_word(s_axi_rdata, ed);
	endtask
	// Live word one edge after a core commit
	task automatic live_is(input logic [31:0] e);
		@(posedge aclk);
		chk_word(live_status, e);
	endtask
	task automatic end_sim();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Cut a hang short well past the hundred or so cycles the tests need
	initial begin
		repeat (4000) @(posedge aclk);
		error_cnt++;
		end_sim();
	end
	// Main sequence
	initial begin
		error_cnt = 0;
		num_checks = 0;
		aresetn = 1'b0;
		ee_reset_cfg = 1'b1;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`SSR_OFF_LIVE, 32'h000003D3, `RESP_OKAY);
		rd(`SSR_OFF_CFG, 32'h00000027, `RESP_OKAY);
		core.wlive(32'h5BA52413);
		live_is(32'h5A052413);
		rd(`SSR_OFF_CUR, 32'h0, `RESP_OKAY);
		core.enter(`MODE_ABT, 32'h20000210);
		live_is(32'h20000217);
		rd(`SSR_OFF_ABT, 32'h0, `RESP_SLVERR);
		rd(`SSR_OFF_CUR, 32'h5A052413, `RESP_OKAY);
		wr(`SSR_OFF_CUR, 32'hFFFFFFF7, `RESP_OKAY);
		rd(`SSR_OFF_CUR, 32'hFE5FFFF7, `RESP_OKAY);
		core.ret();
		live_is(32'hFE5FFFF7);
		chk_word({31'h0, restore_done}, 32'h00000001);
		// If-then clearing, reserved mode and monitor legality
		for (int i = 0; i < 4; i++) begin
			core.sec(sec_tab[i]);
			wr(`SSR_OFF_CUR, wr_tab[i], `RESP_OKAY);
			rd(`SSR_OFF_CUR, exp_tab[i], `RESP_OKAY);
		end
		wr(`SSR_OFF_LIVE, 32'h0, `RESP_OKAY);
		rd(`SSR_OFF_LIVE, 32'hFE5FFFF7, `RESP_OKAY);
		wr(12'h010, 32'h0, `RESP_SLVERR);
		rd(12'h010, 32'h0, `RESP_SLVERR);
		core.enter(`MODE_FIQ, 32'h000000D0);
		rd(`SSR_OFF_CUR, 32'hFE5FFFF7, `RESP_OKAY);
		rd(`SSR_OFF_ABT, 32'h00000016, `RESP_OKAY);
		// Second reset with the strap low: live endianness follows it, banks clear
		ee_reset_cfg <= 1'b0;
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`SSR_OFF_LIVE, 32'h000001D3, `RESP_OKAY);
		rd(`SSR_OFF_ABT, 32'h00000000, `RESP_OKAY);
		end_sim();
	end
endmodule
bind saved_status_register_bank ssr_assertions chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .exc_entry,
	.exc_entry_mode, .exc_entry_status, .exc_return, .live_status, .restore_done);
`default_nettype wire

// >>> dv/ssr_assertions.sv
// Port assertions for the saved status register bank
`timescale 1ns/1ns
`default_nettype none
`include "ssr_regs.svh"
module ssr_assertions import ssr_pkg::*; (
	input wire logic aclk, // Core clock
	input wire logic aresetn, // Reset, active low
	input wire logic s_axi_awvalid, // Write address valid
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_wvalid, // Write data valid
	input wire logic s_axi_wready, // Write data ready
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic exc_entry, // Entry commit
	input wire logic [3:0] exc_entry_mode, // Mode entered
	input wire logic [31:0] exc_entry_status, // Entry word
	input wire logic exc_return, // Return commit
	input wire logic [31:0] live_status, // Live status
	input wire logic restore_done // Restore pulse
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Register bus timing
	aw_drop_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready ##1 s_axi_awready)
		else $error("write address ready did not drop for one cycle");
	bresp_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	rd_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	// Entry capture and the live word fields
	entry_mode_a: assert property (exc_entry && exc_entry_mode == `MODE_ABT |=> live_status[4:0] == 5'h17)
		else $error("entry mode not in live status");
	entry_flags_a: assert property (exc_entry && (exc_entry_mode == `MODE_ABT || exc_entry_mode == `MODE_FIQ)
		|=> live_status[31:27] == $past(exc_entry_status[31:27]))
		else $error("entry flags not taken");
	status_rsv_a: assert property (live_status[24:23] == 2'h0 && !live_status[21] && live_status[4])
		else $error("reserved live bits wrong");
	it_zero_a: assert property (live_status[12:10] == 3'h0 && live_status[26:25] == 2'h0
		|-> live_status[15:13] == 3'h0)
		else $error("if-then field not cleared");
	// Restore completion pulse
	restore_pulse_a: assert property (exc_return && !exc_entry && live_status[3:0] == `MODE_ABT
		|=> restore_done ##1 !restore_done)
		else $error("restore pulse missing");
	done_cause_a: assert property (restore_done |-> $past(exc_return))
		else $error("restore pulse without return");
endmodule
`default_nettype wire

// >>> rtl/saved_status_register_bank.sv
// Saved status register bank with live status, exception capture/restore and AXI4-Lite access
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module saved_status_register_bank import ssr_pkg::*; #(
	parameter bit PAN_PRESENT = 1'b1,
	parameter bit BE_OK = 1'b1,
	parameter bit LE_OK = 1'b1,
	parameter bit BE_EL0_ONLY = 1'b0,
	parameter bit LE_EL0_ONLY = 1'b0,
	parameter bit MON_OK = 1'b1,
	parameter int ADDR_W = 12
) (
	input wire logic aclk, // Core clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic [2:0] s_axi_awprot, // Write protection, unused
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic [2:0] s_axi_arprot, // Read protection, unused
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic ee_reset_cfg, // Endianness reset strap pin
	input wire logic secure_state, // Core is in secure state
	input wire logic exc_entry, // Exception entry commit, one cycle
	input wire logic [3:0] exc_entry_mode, // Mode being entered
	input wire logic [31:0] exc_entry_status, // New live status on entry
	input wire logic exc_return, // Exception return commit, one cycle
	input wire logic live_wr, // Core update of live status
	input wire logic [31:0] live_wr_data, // Live status from core
	output logic [31:0] live_status, // Live status word
	output logic restore_done // Pulse after a restore
);
	status_t live_status_r;
	status_t bank_r [0:6];
	logic ee_s1_r;
	logic ee_s2_r;
	logic aw_have_r;
	logic w_have_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arready_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic restore_done_r;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic wr_go;
	logic aw_have_nxt;
	logic w_have_nxt;
	logic rvalid_nxt;
	bank_t cur_bank;
	bank_t entry_bank;
	bank_t wr_bank;
	logic wr_ok;
	logic [31:0] wmask;
	status_t wr_old;
	status_t wr_merged;
	status_t wr_clean;
	status_t ret_clean;
	status_t live_clean;
	status_t entry_word;
	logic live_e_reset;
	logic [31:0] cfg_word;

	// Strap pin passes two flops before use
	always_ff @(posedge aclk) begin
		ee_s1_r <= ee_reset_cfg;
		ee_s2_r <= ee_s1_r;
	end

	// Endianness at reset follows the strap unless support forces it
	always_comb begin
		if (!BE_OK) begin
			live_e_reset = 1'b0;
		end else if (!LE_OK) begin
			live_e_reset = 1'b1;
		end else begin
			live_e_reset = ee_s2_r;
		end
	end

	assign cur_bank = bank_of(live_status_r[3:0]);
	assign entry_bank = bank_of(exc_entry_mode);

	// Byte strobes to bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_mask
			assign wmask[gi*8 +: 8] = {8{wstrb_r[gi]}};
		end
	endgenerate

	// Decode of the pending write: target bank and permission
	always_comb begin
		wr_bank = BANK_NONE;
		wr_ok = 1'b0;
		if (awaddr_r == ADDR_W'(`SSR_OFF_CUR)) begin
			wr_bank = cur_bank;
			wr_ok = (cur_bank != BANK_NONE);
		end else if (awaddr_r == ADDR_W'(`SSR_OFF_ABT)) begin
			wr_bank = bank_of(`MODE_ABT);
			wr_ok = (live_status_r[3:0] != `MODE_ABT) && (live_status_r[3:0] != `MODE_USR);
		end else if (awaddr_r == ADDR_W'(`SSR_OFF_LIVE) || awaddr_r == ADDR_W'(`SSR_OFF_CFG)) begin
			wr_ok = 1'b1;
		end
	end

	assign wr_old = (wr_bank == BANK_NONE) ? `SAVED_RESET : bank_r[wr_bank];
	assign wr_merged = (wr_old & ~wmask) | (wdata_r & wmask);

	// Cleaning of a software write to a saved register
	status_sanitize #(
		.PAN_PRESENT(PAN_PRESENT),
		.BE_OK(BE_OK),
		.LE_OK(LE_OK),
		.BE_EL0_ONLY(BE_EL0_ONLY),
		.LE_EL0_ONLY(LE_EL0_ONLY),
		.MON_OK(MON_OK)
	) u_wr_clean (
		.raw(wr_merged),
		.old_mode(wr_old[3:0]),
		.is_return(1'b0),
		.secure(secure_state),
		.clean(wr_clean)
	);

	// Cleaning of the restored word on exception return
	status_sanitize #(
		.PAN_PRESENT(PAN_PRESENT),
		.BE_OK(BE_OK),
		.LE_OK(LE_OK),
		.BE_EL0_ONLY(BE_EL0_ONLY),
		.LE_EL0_ONLY(LE_EL0_ONLY),
		.MON_OK(MON_OK)
	) u_ret_clean (
		.raw((cur_bank == BANK_NONE) ? live_status_r : bank_r[cur_bank]),
		.old_mode(live_status_r[3:0]),
		.is_return(1'b1),
		.secure(secure_state),
		.clean(ret_clean)
	);

	// Cleaning of core updates and of the entry status word
	assign entry_word = {exc_entry_status[31:4], exc_entry_mode};
	status_sanitize #(
		.PAN_PRESENT(PAN_PRESENT),
		.BE_OK(BE_OK),
		.LE_OK(LE_OK),
		.BE_EL0_ONLY(BE_EL0_ONLY),
		.LE_EL0_ONLY(LE_EL0_ONLY),
		.MON_OK(MON_OK)
	) u_live_clean (
		.raw((exc_entry && entry_bank != BANK_NONE) ? entry_word : live_wr_data),
		.old_mode(live_status_r[3:0]),
		.is_return(1'b0),
		.secure(secure_state),
		.clean(live_clean)
	);

	// Live status: entry beats return beats core update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			live_status_r <= `LIVE_RESET;
			live_status_r[`SSR_E] <= live_e_reset;
		end else if (exc_entry && entry_bank != BANK_NONE) begin
			live_status_r <= live_clean;
		end else if (exc_return && cur_bank != BANK_NONE) begin
			live_status_r <= ret_clean;
		end else if (live_wr) begin
			live_status_r <= live_clean;
		end
	end

	// Restore completion pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			restore_done_r <= 1'b0;
		end else begin
			restore_done_r <= exc_return && !(exc_entry && entry_bank != BANK_NONE) && cur_bank != BANK_NONE;
		end
	end

	// Saved bank: capture on entry wins over a software write to the same slot
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 7; i++) begin
				bank_r[i] <= `SAVED_RESET;
			end
		end else begin
			if (wr_go && wr_ok && wr_bank != BANK_NONE && !(exc_entry && entry_bank == wr_bank)) begin
				bank_r[wr_bank] <= wr_clean;
			end
			if (exc_entry && entry_bank != BANK_NONE) begin
				// Whole live word copied: flags, if-then, masks, set, mode
				bank_r[entry_bank] <= live_status_r;
			end
		end
	end

	// Write address and data channels, taken in either order
	assign aw_take = s_axi_awvalid & awready_r;
	assign w_take = s_axi_wvalid & wready_r;
	assign wr_go = aw_have_r & w_have_r & ~bvalid_r;
	assign aw_have_nxt = wr_go ? 1'b0 : (aw_take ? 1'b1 : aw_have_r);
	assign w_have_nxt = wr_go ? 1'b0 : (w_take ? 1'b1 : w_have_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			awready_r <= ~aw_have_nxt;
			wready_r <= ~w_have_nxt;
			if (aw_take) begin
				awaddr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
			end
			if (w_take) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Read-only configuration word
	assign cfg_word = {26'h0, MON_OK, LE_EL0_ONLY, BE_EL0_ONLY, LE_OK, BE_OK, PAN_PRESENT};

	// Read channel
	assign ar_take = s_axi_arvalid & arready_r;
	assign rvalid_nxt = ar_take ? 1'b1 : (s_axi_rready ? 1'b0 : rvalid_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			arready_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			arready_r <= ~rvalid_nxt;
			if (ar_take) begin
				rdata_r <= 32'h00000000;
				rresp_r <= `RESP_OKAY;
				if ({s_axi_araddr[ADDR_W-1:2], 2'h0} == ADDR_W'(`SSR_OFF_CUR)) begin
					if (cur_bank != BANK_NONE) begin
						rdata_r <= bank_r[cur_bank];
					end else begin
						rresp_r <= `RESP_SLVERR;
					end
				end else if ({s_axi_araddr[ADDR_W-1:2], 2'h0} == ADDR_W'(`SSR_OFF_ABT)) begin
					if (live_status_r[3:0] != `MODE_ABT && live_status_r[3:0] != `MODE_USR) begin
						rdata_r <= bank_r[bank_of(`MODE_ABT)];
					end else begin
						rresp_r <= `RESP_SLVERR;
					end
				end else if ({s_axi_araddr[ADDR_W-1:2], 2'h0} == ADDR_W'(`SSR_OFF_LIVE)) begin
					rdata_r <= live_status_r;
				end else if ({s_axi_araddr[ADDR_W-1:2], 2'h0} == ADDR_W'(`SSR_OFF_CFG)) begin
					rdata_r <= cfg_word;
				end else begin
					rresp_r <= `RESP_SLVERR;
				end
			end
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign live_status = live_status_r;
	assign restore_done = restore_done_r;
endmodule
`default_nettype wire

// >>> rtl/ssr_pkg.sv
// Types shared by the saved status bank files
package ssr_pkg;
	`include "ssr_regs.svh"
	typedef logic [31:0] status_t;
	typedef logic [3:0] mode_t;
	typedef logic [2:0] bank_t;
	localparam bank_t BANK_NONE = 3'h7;
	// Bank slot of a mode; user and system own no saved register
	function automatic bank_t bank_of(input mode_t m);
		case (m)
			`MODE_FIQ: bank_of = 3'h0;
			`MODE_IRQ: bank_of = 3'h1;
			`MODE_SVC: bank_of = 3'h2;
			`MODE_MON: bank_of = 3'h3;
			`MODE_ABT: bank_of = 3'h4;
			`MODE_HYP: bank_of = 3'h5;
			`MODE_UND: bank_of = 3'h6;
			default: bank_of = BANK_NONE;
		endcase
	endfunction
endpackage

// >>> rtl/ssr_regs.svh
// Offsets, field positions, encodings and reset values of the saved status bank
`ifndef SSR_REGS_SVH
`define SSR_REGS_SVH
`define SSR_OFF_CUR 12'h000
`define SSR_OFF_ABT 12'h004
`define SSR_OFF_LIVE 12'h008
`define SSR_OFF_CFG 12'h00C
`define SSR_FLAGS_HI 31
`define SSR_FLAGS_LO 27
`define SSR_ITL_HI 26
`define SSR_ITL_LO 25
`define SSR_PAN 22
`define SSR_IL 20
`define SSR_GE_HI 19
`define SSR_GE_LO 16
`define SSR_ITH_HI 15
`define SSR_ITH_LO 10
`define SSR_E 9
`define SSR_A 8
`define SSR_I 7
`define SSR_F 6
`define SSR_T 5
`define SSR_M4 4
`define SSR_RSV0_MASK 32'h01A00000
`define MODE_USR 4'h0
`define MODE_FIQ 4'h1
`define MODE_IRQ 4'h2
`define MODE_SVC 4'h3
`define MODE_MON 4'h6
`define MODE_ABT 4'h7
`define MODE_HYP 4'hA
`define MODE_UND 4'hB
`define MODE_SYS 4'hF
`define LIVE_RESET 32'h000001D3
`define SAVED_RESET 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> rtl/status_sanitize.sv
// Forces reserved, optional and constrained fields of a status word
`timescale 1ns/1ns
`default_nettype none
module status_sanitize import ssr_pkg::*; #(
	parameter bit PAN_PRESENT = 1'b1,
	parameter bit BE_OK = 1'b1,
	parameter bit LE_OK = 1'b1,
	parameter bit BE_EL0_ONLY = 1'b0,
	parameter bit LE_EL0_ONLY = 1'b0,
	parameter bit MON_OK = 1'b1
) (
	input wire logic [31:0] raw, // Word to clean
	input wire logic [3:0] old_mode, // Mode kept if raw mode is illegal
	input wire logic is_return, // Word is an exception return target
	input wire logic secure, // Secure state
	output logic [31:0] clean // Cleaned word
);
	logic mode_ok;
	logic to_upper;

	// Legal mode encodings; monitor only when secure and allowed
	always_comb begin
		case (raw[3:0])
			`MODE_USR, `MODE_FIQ, `MODE_IRQ, `MODE_SVC, `MODE_ABT, `MODE_HYP, `MODE_UND, `MODE_SYS: mode_ok = 1'b1;
			`MODE_MON: mode_ok = secure & MON_OK;
			default: mode_ok = 1'b0;
		endcase
	end

	assign to_upper = is_return & (raw[3:0] != `MODE_USR);

	// Field forcing
	always_comb begin
		clean = raw & ~`SSR_RSV0_MASK;
		if (!PAN_PRESENT) begin
			clean[`SSR_PAN] = 1'b0;
		end
		// No active block means the whole field reads zero
		if ({raw[12:10], raw[26:25]} == 5'h00) begin
			clean[`SSR_ITH_HI:13] = 3'h0;
		end
		if (!BE_OK || (BE_EL0_ONLY && to_upper)) begin
			clean[`SSR_E] = 1'b0;
		end else if (!LE_OK || (LE_EL0_ONLY && to_upper)) begin
			clean[`SSR_E] = 1'b1;
		end
		clean[`SSR_M4] = 1'b1;
		if (!mode_ok) begin
			clean[3:0] = old_mode;
		end
	end
endmodule
`default_nettype wire
